// >>> hdl/strobe_gate_ctrl.sv
// Top of the alignment strobe gating block: APB registers, gates, one-shot clears.
// Assumes an APB master on pclk and an asynchronous strobe pin from system logic.
`timescale 1ns/10ps
module strobe_gate_ctrl
    import strobe_gate_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        strobe_pin,
    output stage_sync_t      stage_sync,
    output logic             wide_osc_load,
    output logic      [15:0] phase_offset,
    output logic             low_latency_sel,
    output logic             strobe_buf_en
);
    ////////////////////////////////////////////////////////////////////////////////
    // Storage, stage layout and internal nets.

    // Stages in loop order: 0 filter, 1 wide oscillator, 2 quarter-rate oscillator.
    localparam int NUM_STAGES = 3;

    // Enable and next-only bit positions of each stage, three bits per stage.
    // Stage 0 sits in the lowest three bits of each constant.
    localparam logic [8:0] EN_POS   = {3'(QTR_EN_BIT), 3'(WIDE_EN_BIT), 3'(FILT_EN_BIT)};
    localparam logic [8:0] NEXT_POS = {3'(QTR_NEXT_BIT), 3'(WIDE_NEXT_BIT), 3'(FILT_NEXT_BIT)};

    logic [7:0]                 master_r;
    logic [7:0]                 stage_r;
    logic [7:0]                 stage_nxt;
    logic [7:0]                 pin_r;
    logic [7:0]                 osc2_r;
    logic [15:0]                phase_r;
    logic [31:0]                rdata_r;
    logic                       qual_w;
    wire  [NUM_STAGES-1:0]      go_w;
    wire  [NUM_STAGES-1:0][7:0] clr_mask_w;
    logic [NUM_STAGES-1:0]      pulse_r;
    logic                       load_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus decode.

    // Zero-wait slave: the access phase completes at its first edge.
    // Every qualifier below includes ce, so a frozen block takes no write
    // and captures no read data.
    wire        access_w   = psel & penable & ce;
    wire        wr_w       = access_w & pwrite;
    wire        rd_setup_w = psel & ~penable & ~pwrite & ce;
    wire [9:0]  idx_full   = paddr[11:2];
    wire [7:0]  idx_w      = idx_full[7:0];

    // Only aligned words whose index fits in eight bits can hit a register.
    wire        hi_zero  = (idx_full[9:8] == 2'b00) & (paddr[1:0] == 2'b00);
    wire        hit_m    = hi_zero & (idx_w == MASTER_IDX);
    wire        hit_s    = hi_zero & (idx_w == STAGE_IDX);
    wire        hit_p    = hi_zero & (idx_w == PIN_IDX);
    wire        hit_o    = hi_zero & (idx_w == OSC2_IDX);
    wire        hit_ph   = hi_zero & (idx_w == PHASE_IDX);
    wire        hit_any  = hit_m | hit_s | hit_p | hit_o | hit_ph;

    // The slave never stretches a transfer; only unmapped words are flagged.
    assign pready  = 1'b1;
    assign pslverr = access_w & ~hit_any;
    assign prdata  = rdata_r;

    // Read data mux; reserved bits and unmapped addresses read zero.
    wire [31:0] rmux_w = hit_m  ? {24'h00_0000, master_r} :
                         hit_s  ? {24'h00_0000, stage_r}  :
                         hit_p  ? {24'h00_0000, pin_r}    :
                         hit_o  ? {24'h00_0000, osc2_r}   :
                         hit_ph ? {16'h0000, phase_r}     : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Strobe qualification.

    // The qualifier synchronizes the pin through two flip-flops before any logic
    // looks at it, so a strobe reaches the stage outputs two edges after the
    // pin is first sampled high. In level mode it pulses on every high cycle.
    strobe_qualifier strobe_qualifier_inst (
        .pclk       (pclk),
        .presetn    (presetn),
        .ce         (ce),
        .strobe_pin (strobe_pin),
        .edge_mode  (pin_r[SENSE_BIT]),
        .rising_sel (pin_r[EDGE_SEL_BIT]),
        .qual_pulse (qual_w)
    );

    // Master gate shared by every stage; with the bit low nothing passes.
    wire master_w = master_r[MASTER_EN_BIT];
    wire gated_w  = qual_w & master_w;

    ////////////////////////////////////////////////////////////////////////////////
    // Per-stage gates and one-shot clears.

    // Each stage passes the gated strobe while its enable bit is high. When its
    // next-only bit is also set, the same strobe clears the enable bit, so the
    // stage syncs once and ignores later strobes until software enables it again.
    genvar g;
    for (g = 0; g < NUM_STAGES; g = g + 1) begin : gen_stage
        localparam logic [2:0] EN_AT   = EN_POS[3*g +: 3];
        localparam logic [2:0] NEXT_AT = NEXT_POS[3*g +: 3];
        assign go_w[g]       = gated_w & stage_r[EN_AT];
        assign clr_mask_w[g] = (go_w[g] & stage_r[NEXT_AT]) ? (8'h01 << EN_AT)
                                                            : 8'h00;
    end

    // Software writes land first; a one-shot clear in the same cycle then wins,
    // so a strobe that arrives with the write still disarms the stage.
    wire [7:0] clr_all_w  = clr_mask_w[0] | clr_mask_w[1] | clr_mask_w[2];
    wire [7:0] stage_wr_w = (wr_w & hit_s) ? (pwdata[7:0] & STAGE_MASK) : stage_r;
    assign stage_nxt      = stage_wr_w & ~clr_all_w;

    // Starting the wide oscillator from software also reloads its phase.
    wire wide_start_w = wr_w & hit_s & pwdata[WIDE_EN_BIT] & ~stage_r[WIDE_EN_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    // Master strobe buffer enable; reserved bits are masked off on write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_r <= MASTER_RST;
        end else if (wr_w && hit_m) begin
            master_r <= pwdata[7:0] & MASTER_MASK;
        end
    end

    // Stage enables; ce freezes the one-shot clears as well as the writes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_r <= STAGE_RST;
        end else if (ce) begin
            stage_r <= stage_nxt;
        end
    end

    // Pin sensitivity and edge polarity.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_r <= PIN_RST;
        end else if (wr_w && hit_p) begin
            pin_r <= pwdata[7:0] & PIN_MASK;
        end
    end

    // Low-latency oscillator select.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc2_r <= OSC2_RST;
        end else if (wr_w && hit_o) begin
            osc2_r <= pwdata[7:0] & OSC2_MASK;
        end
    end

    // Phase offset handed to the wide oscillator on every load.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= PHASE_RST;
        end else if (wr_w && hit_ph) begin
            phase_r <= pwdata[15:0];
        end
    end

    // Read data is captured in the setup cycle and stands through the access.
    // A one-shot clear landing between setup and access shows on the next read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h0000_0000;
        end else if (rd_setup_w) begin
            rdata_r <= rmux_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Stage outputs.

    // Registered stage pulses and the phase load, one cycle each.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_r <= '0;
            load_r  <= 1'b0;
        end else if (ce) begin
            pulse_r <= go_w;
            load_r  <= go_w[1] | wide_start_w;
        end
    end

    // Struct order is filter, wide oscillator, quarter-rate, most significant first.
    assign stage_sync      = stage_sync_t'({pulse_r[0], pulse_r[1], pulse_r[2]});
    assign wide_osc_load   = load_r;
    assign phase_offset    = phase_r;
    assign low_latency_sel = osc2_r[LOWLAT_BIT];
    assign strobe_buf_en   = master_w;

endmodule

// >>> hdl/strobe_gate_pkg.sv
// Constants, register map and carrier types for the alignment strobe gating block.
// Assumes an APB master on pclk with 32-bit data; offsets are register indices.
// How it works
// - Filter enable high: every qualified strobe resyncs the filter decimator, repeatedly.
// - No stage gets any strobe while the master buffer enable bit is low.
// - Wide oscillator next-only: sync on first strobe, then clear its enable bit.
// - Wide oscillator enable high: each strobe restarts its accumulator at phase offset.
// - Sensitivity bit 0 selects level qualification, 1 selects edge qualification.
// - In edge mode, edge select 0 means falling edge, 1 means rising edge.
// - Low-latency select bit 1 routes the datapath to the low-latency oscillator.
// - Master enable must be high before any strobe function works; low saves power.
// - Filter next-only bit: resync the filter on the first strobe only.
// - Quarter-rate enable gates its strobes; with next-only it clears after one.
// - Phase offset loads into the oscillator on start and on every resync.
package strobe_gate_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [7:0] MASTER_IDX   = 8'h3a;
    localparam logic [7:0] STAGE_IDX    = 8'h58;
    localparam logic [7:0] PIN_IDX      = 8'h59;
    localparam logic [7:0] OSC2_IDX     = 8'h5a;
    localparam logic [7:0] PHASE_IDX    = 8'h5b;

    // Field positions.
    localparam int MASTER_EN_BIT   = 0;
    localparam int WIDE_EN_BIT     = 0;
    localparam int WIDE_NEXT_BIT   = 1;
    localparam int FILT_EN_BIT     = 4;
    localparam int FILT_NEXT_BIT   = 5;
    localparam int QTR_EN_BIT      = 6;
    localparam int QTR_NEXT_BIT    = 7;
    localparam int EDGE_SEL_BIT    = 0;
    localparam int SENSE_BIT       = 1;
    localparam int LOWLAT_BIT      = 0;

    // Reset values.
    localparam logic [7:0]  MASTER_RST = 8'h00;
    localparam logic [7:0]  STAGE_RST  = 8'h00;
    localparam logic [7:0]  PIN_RST    = 8'h00;
    localparam logic [7:0]  OSC2_RST   = 8'h00;
    localparam logic [15:0] PHASE_RST  = 16'h0000;

    // Writable bit masks; other bits are reserved and read zero.
    localparam logic [7:0] MASTER_MASK = 8'h01;
    localparam logic [7:0] STAGE_MASK  = 8'hf3;
    localparam logic [7:0] PIN_MASK    = 8'h03;
    localparam logic [7:0] OSC2_MASK   = 8'h01;

    // Per-stage sync pulses to the processing stages.
    typedef struct packed {
        logic filter_sync;
        logic wide_osc_sync;
        logic qtr_osc_sync;
    } stage_sync_t;

endpackage

// >>> hdl/strobe_qualifier.sv
// Synchronizes the alignment strobe pin and qualifies level or edge events.
// Assumes the pin is asynchronous to pclk.
`timescale 1ns/10ps
module strobe_qualifier
    import strobe_gate_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic strobe_pin,
    input  wire logic edge_mode,
    input  wire logic rising_sel,
    output logic      qual_pulse
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // Two-stage synchronizer plus one history stage for edges.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else if (ce) begin
            meta_r <= strobe_pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    wire rise_w  = sync_r & ~prev_r;
    wire fall_w  = ~sync_r & prev_r;
    wire edge_w  = rising_sel ? rise_w : fall_w;

    // Level mode gives a pulse per cycle the strobe stays high.
    assign qual_pulse = ce & (edge_mode ? edge_w : sync_r);

endmodule

// >>> test/strobe_src_model.sv
// Model of the system logic driving the alignment strobe pin.
// Assumes the bench asks for a strobe of len cycles by raising go.
`timescale 1ns/10ps
module strobe_src_model (
    input  wire logic       pclk,
    input  wire logic       go,
    input  wire logic [3:0] len,
    output logic            strobe_pin
);
    logic [3:0] left_r = 4'h0;

    // Holds the active-high pin for len cycles; it idles low between strobes.
    always_ff @(posedge pclk) begin
        if (go) begin
            left_r <= len;
        end else if (left_r != 4'h0) begin
            left_r <= left_r - 4'h1;
        end
    end
    assign strobe_pin = (left_r != 4'h0);
endmodule

// >>> test/strobe_gate_ctrl_monitor.sv
// Port checker of the strobe gating block.
// Assumes it is bound to strobe_gate_ctrl.
`timescale 1ns/10ps
module strobe_gate_ctrl_monitor
    import strobe_gate_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        strobe_pin,
    input wire stage_sync_t stage_sync,
    input wire logic        wide_osc_load,
    input wire logic [15:0] phase_offset,
    input wire logic        low_latency_sel,
    input wire logic        strobe_buf_en
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A register write is taken only in an enabled access cycle.
    wire wr = psel && penable && pwrite && ce;

    a_master_gate: assert property (stage_sync != 3'h0 |->
        strobe_buf_en || $past(strobe_buf_en))
        else $error("stage pulse without master enable");
    a_pin_cause: assert property (stage_sync != 3'h0 |->
        $past(strobe_pin, 3) || $past(strobe_pin, 4) || $past(strobe_pin, 5))
        else $error("stage pulse without strobe");
    a_load_on_sync: assert property (stage_sync.wide_osc_sync |-> ##[0:1] wide_osc_load)
        else $error("wide resync without phase load");
    a_phase_hold: assert property (!wr |=> $stable(phase_offset))
        else $error("phase offset moved without write");
    a_lowlat_hold: assert property (!wr |=> $stable(low_latency_sel))
        else $error("latency select moved without write");
    a_master_hold: assert property (!wr |=> $stable(strobe_buf_en))
        else $error("master enable moved without write");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    a_ready_high: assert property (pready)
        else $error("ready low");

    c_filter: cover property (stage_sync.filter_sync);
    c_wide: cover property (stage_sync.wide_osc_sync ##1 !stage_sync.wide_osc_sync);
    c_qtr: cover property (stage_sync.qtr_osc_sync);
endmodule

bind strobe_gate_ctrl strobe_gate_ctrl_monitor strobe_gate_ctrl_monitor_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .strobe_pin(strobe_pin),
    .stage_sync(stage_sync), .wide_osc_load(wide_osc_load), .phase_offset(phase_offset),
    .low_latency_sel(low_latency_sel), .strobe_buf_en(strobe_buf_en));

// >>> test/strobe_gate_ctrl_tb_top.sv
// Testbench of the strobe gating block: APB tasks, strobe model, pulse counts.
// Assumes the design package and the strobe source model.
`timescale 1ns/10ps
module strobe_gate_ctrl_tb_top;
    import strobe_gate_pkg::*;
    logic        pclk = 0, presetn = 0, ce = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd_v, er_v;
    logic        pready, pslverr, strobe_pin, wide_osc_load, low_latency_sel, strobe_buf_en;
    logic [15:0] phase_offset;
    logic [3:0]  len = 4'h1;
    stage_sync_t stage_sync;
    int          err_count = 0, tests_run = 0, n_f = 0, n_w = 0, n_q = 0, n_l = 0;
    logic [7:0]  ix [5] = '{MASTER_IDX, STAGE_IDX, PIN_IDX, OSC2_IDX, PHASE_IDX};
    logic [31:0] mk [5] = '{32'h0000_0001, 32'h0000_00f3, 32'h0000_0003, 32'h0000_0001,
                            32'h0000_ffff};

    always #2.5 pclk = ~pclk;
    strobe_gate_ctrl strobe_gate_ctrl_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .strobe_pin(strobe_pin),
        .stage_sync(stage_sync), .wide_osc_load(wide_osc_load), .phase_offset(phase_offset),
        .low_latency_sel(low_latency_sel), .strobe_buf_en(strobe_buf_en));
    strobe_src_model strobe_src_model_inst (.pclk(pclk), .go(go), .len(len),
        .strobe_pin(strobe_pin));

    // Counts the pulses of every stage output.
    always @(posedge pclk) begin
        n_f <= n_f + int'(stage_sync.filter_sync);
        n_w <= n_w + int'(stage_sync.wide_osc_sync);
        n_q <= n_q + int'(stage_sync.qtr_osc_sync);
        n_l <= n_l + int'(wide_osc_load);
    end

    task automatic results;
        $display("compares %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
        int k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd_v = prdata;
        er_v = {31'h0000_0000, pslverr};
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            err_count++;
            results();
        end
    endtask

    // Sends one strobe and compares the pulses seen per stage.
    task automatic fire(input logic [3:0] l, input int ef, input int ew, input int eq);
        int f0 = n_f, w0 = n_w, q0 = n_q, l0 = n_l;
        @(posedge pclk);
        go <= 1'b1;
        len <= l;
        @(posedge pclk);
        go <= 1'b0;
        repeat (16) @(posedge pclk);
        chk(n_f - f0, ef);
        chk(n_w - w0, ew);
        chk(n_q - q0, eq);
        chk(n_l - l0, ew);
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        ce <= 1'b1;
        for (int j = 0; j < 5; j++) begin
            apb(1'b0, ix[j], 32'h0000_0000);
            chk(rd_v, 32'h0000_0000);
            // Low-latency select is set here only to read it back; the frequency
            // word that software must pair with it lives outside this block.
            apb(1'b1, ix[j], 32'hffff_ffff);
            apb(1'b0, ix[j], 32'h0000_0000);
            chk(rd_v, mk[j]);
        end
        chk({31'h0000_0000, low_latency_sel}, 32'h0000_0001);
        chk({31'h0000_0000, strobe_buf_en}, 32'h0000_0001);
        chk({16'h0000, phase_offset}, 32'h0000_ffff);
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk(er_v, 32'h0000_0001);
        apb(1'b1, ix[0], 32'h0000_0000);
        apb(1'b1, PIN_IDX, 32'h0000_0000);
        chk({31'h0000_0000, strobe_buf_en}, 32'h0000_0000);
        apb(1'b1, STAGE_IDX, 32'h0000_0051);
        fire(4'h3, 0, 0, 0);
        apb(1'b1, ix[0], 32'h0000_0001);
        fire(4'h3, 3, 3, 3);
        chk({31'h0000_0000, strobe_buf_en}, 32'h0000_0001);
        fire(4'h2, 2, 2, 2);
        // A strobe while the clock enable is low must leave no trace.
        ce <= 1'b0;
        fire(4'h3, 0, 0, 0);
        ce <= 1'b1;
        apb(1'b1, PIN_IDX, 32'h0000_0003);
        fire(4'h4, 1, 1, 1);
        apb(1'b1, PIN_IDX, 32'h0000_0002);
        fire(4'h4, 1, 1, 1);
        apb(1'b1, PIN_IDX, 32'h0000_0003);
        for (int b = 0; b < 7; b += 2 + 2 * int'(b == 0)) begin
            apb(1'b1, STAGE_IDX, 32'h0000_0003 << b);
            fire(4'h3, int'(b == 4), int'(b == 0), int'(b == 6));
            apb(1'b0, STAGE_IDX, 32'h0000_0000);
            chk(rd_v, 32'h0000_0002 << b);
            fire(4'h3, 0, 0, 0);
        end
        results();
    end
endmodule
